// File: design/dram_power_down_reset.sv
`timescale 1ns/1ps
// Contract
// - Open bank after pending commands finish gives active power-down.
// - All banks closed after pending commands finish gives precharge power-down.
// - Mode bit 12 picks precharge exit: 1 fast with DLL on, 0 slow.
// - Active power-down keeps the DLL on and always exits fast.
// - RESET# falling in power-down leaves it at once for reset.
// - CKE sampled high with NOP exits power-down on that edge.
// - Write recovery field holds recovery time over clock period, rounded up.
// - RESET# is an asynchronous reset acting whenever it falls.
// - During reset outputs disabled, termination off, state cleared.
// - Reset clears refresh counters and marks array contents unknown.
// - Termination applies per data, strobe and mask pin group.
// - No on-die termination while the DLL is disabled.
// - CKE sampled low with NOP enters power-down on that edge; the code enters PD_PEND there, power-down a later edge.
// - Entry disables input buffers except clock, ODT, CKE and reset.
// - Slow precharge power-down runs ODT asynchronously until relock ends.
module dram_power_down_reset #(
   parameter int DQ_W = 8,
   parameter int XP = dram_pd_pkg::XP_CYC,
   parameter int XPDLL = dram_pd_pkg::XPDLL_CYC,
   parameter int CPDED = dram_pd_pkg::CPDED_CYC,
   parameter int REF_W = 16
) (
   // Core clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Link clock and pins
   input wire logic ck_i,
   input wire logic reset_n_i,
   input wire logic cke_i,
   input wire logic nop_i,
   input wire logic refresh_i,
   input wire logic odt_i,
   input wire logic rd_drive_i,
   // Core side levels
   input wire logic bank_open_i,
   input wire logic op_busy_i,
   input wire logic dll_disable_i,
   input wire logic [dram_pd_pkg::MR0_W-1:0] mr0_i,
   input wire logic init_done_i,
   // Link side status
   output logic out_en_n_o,
   output logic [((DQ_W+7)/8)-1:0] rtt_en_o,
   output logic in_buf_en_o,
   output logic dll_on_o,
   output logic odt_async_o,
   output logic cmd_ok_o,
   output logic dll_cmd_ok_o,
   output logic [2:0] wr_rec_o,
   // Core side status
   output logic pd_active_o,
   output logic pd_precharge_o,
   output logic dll_locked_o,
   output logic array_unknown_o,
   output logic [REF_W-1:0] refresh_cnt_o
);

   localparam int GROUPS = (DQ_W + 7) / 8;
   localparam int TW = dram_pd_pkg::TMR_W;

   dram_pd_pkg::pd_state_e state_r;
   dram_pd_pkg::pd_state_e state_nxt;
   logic lrst_n;
   logic [3:0] in_s1_r;
   logic [3:0] in_s2_r;
   logic [2:0] wr_s1_r;
   logic [2:0] wr_s2_r;
   logic bank_s;
   logic busy_s;
   logic fast_s;
   logic dll_dis_s;
   logic in_pd;
   logic pd_exit;
   logic slow_exit;
   logic xp_done;
   logic xpdll_done;
   logic relock_r;
   logic dll_locked_r;
   logic rtt_on_r;
   logic [TW-1:0] cp_r;
   logic ref_tgl_r;
   logic [2:0] st_s1_r;
   logic [2:0] st_s2_r;
   logic [2:0] st_lnk_r;
   logic rst_s1_r;
   logic rst_s2_r;
   logic [2:0] ref_s_r;
   logic [REF_W-1:0] ref_cnt_r;
   logic unknown_r;

   // Link logic is cleared by either the core reset or the RESET# pin
   assign lrst_n = nrst_i & reset_n_i;

   // Core levels into the link domain, two flops each
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         in_s1_r <= '0;
         in_s2_r <= '0;
         wr_s1_r <= '0;
         wr_s2_r <= '0;
      end else begin
         in_s1_r <= {dll_disable_i, mr0_i[dram_pd_pkg::MR0_PPD_BIT], op_busy_i, bank_open_i};
         in_s2_r <= in_s1_r;
         wr_s1_r <= mr0_i[dram_pd_pkg::MR0_WR_MSB:dram_pd_pkg::MR0_WR_LSB];
         wr_s2_r <= wr_s1_r;
      end
   end

   assign bank_s = in_s2_r[0];
   assign busy_s = in_s2_r[1];
   assign fast_s = in_s2_r[2];
   assign dll_dis_s = in_s2_r[3];

   assign in_pd = (state_r == dram_pd_pkg::PD_ACTIVE) || (state_r == dram_pd_pkg::PD_PRE_FAST) ||
                  (state_r == dram_pd_pkg::PD_PRE_SLOW);
   assign pd_exit = (in_pd || state_r == dram_pd_pkg::PD_PEND) && cke_i;
   assign slow_exit = (state_r == dram_pd_pkg::PD_PRE_SLOW) && cke_i;

   // Entry and exit decisions
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dram_pd_pkg::PD_IDLE: begin
            if (!cke_i && nop_i) begin
               state_nxt = dram_pd_pkg::PD_PEND;
            end
         end
         dram_pd_pkg::PD_PEND: begin
            if (cke_i) begin
               state_nxt = dram_pd_pkg::PD_IDLE;
            end else if (!busy_s && bank_s) begin
               state_nxt = dram_pd_pkg::PD_ACTIVE;
            end else if (!busy_s && fast_s) begin
               state_nxt = dram_pd_pkg::PD_PRE_FAST;
            end else if (!busy_s) begin
               state_nxt = dram_pd_pkg::PD_PRE_SLOW;
            end
         end
         dram_pd_pkg::PD_ACTIVE, dram_pd_pkg::PD_PRE_FAST, dram_pd_pkg::PD_PRE_SLOW: begin
            if (cke_i) begin
               state_nxt = dram_pd_pkg::PD_IDLE;
            end
         end
         default: begin
            state_nxt = dram_pd_pkg::PD_IDLE;
         end
      endcase
   end

   // State register; a falling RESET# drops any power-down at once
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         state_r <= dram_pd_pkg::PD_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Exit latency, counted from the exit edge
   pd_timer #(
      .W(TW)
   ) u_xp (
      .clk_i(ck_i),
      .rst_n_i(lrst_n),
      .load_i(pd_exit),
      .count_i(TW'(XP)),
      .done_o(xp_done)
   );

   // DLL relock time after a slow exit
   pd_timer #(
      .W(TW)
   ) u_xpdll (
      .clk_i(ck_i),
      .rst_n_i(lrst_n),
      .load_i(slow_exit),
      .count_i(TW'(XPDLL)),
      .done_o(xpdll_done)
   );

   // DLL lock flag: dropped in slow power-down, regained once relock time ends
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         dll_locked_r <= dram_pd_pkg::RST_DLL_LOCKED;
         relock_r <= 1'b0;
      end else if (state_r == dram_pd_pkg::PD_PRE_SLOW) begin
         dll_locked_r <= 1'b0;
         relock_r <= 1'b1;
      end else if (relock_r && xpdll_done) begin
         dll_locked_r <= 1'b1;
         relock_r <= 1'b0;
      end else if (!relock_r && !dll_dis_s && state_r == dram_pd_pkg::PD_IDLE) begin
         dll_locked_r <= 1'b1;
      end
   end

   // Input buffers shut off a few clocks into power-down
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         cp_r <= '0;
         in_buf_en_o <= 1'b0;
      end else if (in_pd && !cke_i) begin
         if (cp_r != TW'(CPDED)) begin
            cp_r <= cp_r + TW'(1);
         end
         in_buf_en_o <= (cp_r != TW'(CPDED));
      end else begin
         cp_r <= '0;
         in_buf_en_o <= 1'b1;
      end
   end

   // DLL, ODT mode, command permission and registered status for the core side
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         dll_on_o <= 1'b0;
         odt_async_o <= 1'b0;
         cmd_ok_o <= 1'b0;
         dll_cmd_ok_o <= 1'b0;
         wr_rec_o <= '0;
         st_lnk_r <= '0;
      end else begin
         dll_on_o <= !dll_dis_s && (state_nxt != dram_pd_pkg::PD_PRE_SLOW);
         odt_async_o <= (state_r == dram_pd_pkg::PD_PRE_SLOW) || relock_r;
         cmd_ok_o <= (state_r == dram_pd_pkg::PD_IDLE) && xp_done && !pd_exit;
         dll_cmd_ok_o <= (state_r == dram_pd_pkg::PD_IDLE) && xp_done && dll_locked_r && !relock_r;
         wr_rec_o <= wr_s2_r;
         st_lnk_r <= {dll_locked_r, in_pd && (state_r != dram_pd_pkg::PD_ACTIVE), state_r == dram_pd_pkg::PD_ACTIVE};
      end
   end

   // Output driver and termination; both off during reset, termination also off without the DLL
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         out_en_n_o <= dram_pd_pkg::RST_OUT_EN_N;
         rtt_on_r <= 1'b0;
      end else begin
         out_en_n_o <= !(rd_drive_i && state_r == dram_pd_pkg::PD_IDLE);
         rtt_on_r <= odt_i && !dll_dis_s && !rd_drive_i;
      end
   end

   // One termination switch per byte group of data, strobe and mask pins
   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : g_rtt
         always_ff @(posedge ck_i or negedge lrst_n) begin
            if (!lrst_n) begin
               rtt_en_o[g] <= 1'b0;
            end else begin
               rtt_en_o[g] <= rtt_on_r;
            end
         end
      end
   endgenerate

   // Refresh events leave the link domain as a toggle
   always_ff @(posedge ck_i or negedge lrst_n) begin
      if (!lrst_n) begin
         ref_tgl_r <= 1'b0;
      end else if (refresh_i && state_r == dram_pd_pkg::PD_IDLE) begin
         ref_tgl_r <= ~ref_tgl_r;
      end
   end

   // Link state and RESET# pin into the core domain
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_s1_r <= '0;
         st_s2_r <= '0;
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
         ref_s_r <= '0;
      end else begin
         st_s1_r <= st_lnk_r; // Glitch-free: launched from link flops
         st_s2_r <= st_s1_r;
         rst_s1_r <= lrst_n;
         rst_s2_r <= rst_s1_r;
         ref_s_r <= {ref_s_r[1:0], ref_tgl_r};
      end
   end

   // Refresh counter cleared and array content flag set by any reset
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_cnt_r <= '0;
         unknown_r <= 1'b1;
      end else if (!rst_s2_r) begin
         ref_cnt_r <= '0;
         unknown_r <= 1'b1;
      end else begin
         if (ref_s_r[1] != ref_s_r[2]) begin
            ref_cnt_r <= ref_cnt_r + REF_W'(1);
         end
         if (init_done_i) begin
            unknown_r <= 1'b0;
         end
      end
   end

   // Core side status from flops
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pd_active_o <= 1'b0;
         pd_precharge_o <= 1'b0;
         dll_locked_o <= 1'b0;
      end else begin
         pd_active_o <= st_s2_r[0];
         pd_precharge_o <= st_s2_r[1];
         dll_locked_o <= st_s2_r[2];
      end
   end

   assign refresh_cnt_o = ref_cnt_r;
   assign array_unknown_o = unknown_r;

   // Checks on the link clock
   a_active_pd_bank: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (state_r == dram_pd_pkg::PD_PEND && !cke_i && !busy_s && bank_s) |=>
      (state_r == dram_pd_pkg::PD_ACTIVE))
      else $error("open bank did not give active power-down");
   a_pre_pd_closed: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (state_r == dram_pd_pkg::PD_PEND && !cke_i && !busy_s && !bank_s) |=>
      (state_r == dram_pd_pkg::PD_PRE_FAST || state_r == dram_pd_pkg::PD_PRE_SLOW))
      else $error("closed banks did not give precharge power-down");
   a_pre_exit_mode: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (state_r == dram_pd_pkg::PD_PEND && !cke_i && !busy_s && !bank_s) |=>
      ((state_r == dram_pd_pkg::PD_PRE_FAST) == $past(fast_s)))
      else $error("precharge exit mode does not follow mode bit");
   a_active_dll_on: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (state_r == dram_pd_pkg::PD_ACTIVE && $past(state_r == dram_pd_pkg::PD_ACTIVE) && !dll_dis_s
       && $past(!dll_dis_s)) |-> dll_on_o)
      else $error("DLL off in active power-down");
   a_exit_on_cke: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (in_pd && cke_i) |=> (state_r == dram_pd_pkg::PD_IDLE) ##1 !cmd_ok_o)
      else $error("power-down not left on CKE high");
   a_entry_on_cke: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (state_r == dram_pd_pkg::PD_IDLE && !cke_i && nop_i) |=> (state_r != dram_pd_pkg::PD_IDLE))
      else $error("power-down not entered on CKE low");
   a_slow_relock: assert property (@(posedge ck_i) disable iff (!lrst_n)
      slow_exit |=> !dll_cmd_ok_o [*8] ##[1:8] dll_locked_r)
      else $error("DLL relock window wrong after slow exit");
   a_no_odt_dlloff: assert property (@(posedge ck_i) disable iff (!lrst_n)
      dll_dis_s |=> ##1 (rtt_en_o == '0))
      else $error("termination on with DLL disabled");
   a_buf_off_pd: assert property (@(posedge ck_i) disable iff (!lrst_n)
      (in_pd && !cke_i) [*3] |=> !in_buf_en_o)
      else $error("input buffers still on in power-down");
   c_active_pd: cover property (@(posedge ck_i) disable iff (!lrst_n)
      state_r == dram_pd_pkg::PD_ACTIVE ##1 state_r == dram_pd_pkg::PD_IDLE);
   c_fast_pd: cover property (@(posedge ck_i) disable iff (!lrst_n)
      state_r == dram_pd_pkg::PD_PRE_FAST ##1 state_r == dram_pd_pkg::PD_IDLE);
   c_slow_relock: cover property (@(posedge ck_i) disable iff (!lrst_n)
      slow_exit ##[1:20] dll_cmd_ok_o);

endmodule

// File: design/dram_pd_pkg.sv
package dram_pd_pkg;

   // Mode register 0 field positions
   localparam int MR0_W = 16;
   localparam int MR0_WR_LSB = 9;
   localparam int MR0_WR_MSB = 11;
   localparam int MR0_PPD_BIT = 12;

   // Clock periods, in ns
   localparam int CLK_PERIOD_NS = 4;

   // DLL relock after a slow exit: the greater of a clock count and a time
   localparam int T_XPDLL_NS = 24;
   localparam int XPDLL_MIN_TCK = 10;
   localparam int XPDLL_NS_CYC = (T_XPDLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XPDLL_CYC = (XPDLL_NS_CYC > XPDLL_MIN_TCK) ? XPDLL_NS_CYC : XPDLL_MIN_TCK;

   // Exit latency and buffer shut-off delay, in link clocks
   localparam int XP_CYC = 3;
   localparam int CPDED_CYC = 1;

   // Width of the latency counters
   localparam int TMR_W = 5;

   // Reset values
   localparam logic RST_DLL_LOCKED = 1'b0;
   localparam logic RST_OUT_EN_N = 1'b1;

   // Power-down state machine
   typedef enum logic [2:0] {
      PD_IDLE,
      PD_PEND,
      PD_ACTIVE,
      PD_PRE_FAST,
      PD_PRE_SLOW
   } pd_state_e;

endpackage

// File: design/pd_timer.sv
`timescale 1ns/1ps
// Down counter: loads a latency and reports when it has run out
module pd_timer #(
   parameter int W = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic load_i,
   input wire logic [W-1:0] count_i,
   // Status
   output logic done_o
);

   logic [W-1:0] cnt_r;

   // Count down to zero and stop there
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
      end else if (load_i) begin
         cnt_r <= count_i;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - W'(1);
      end
   end

   assign done_o = (cnt_r == '0);

endmodule

// File: testbench/ddr_ctrl_model.sv
`timescale 1ns/1ps
// Controller-side model: free-running command clock and CKE sequencing
module ddr_ctrl_model #(
   parameter int T_PD = 3,
   parameter int T_XP = 3,
   parameter int T_GAP = 12
) (
   // Link clock and pins
   output logic ck_o,
   output logic reset_n_o,
   output logic cke_o,
   output logic nop_o,
   output logic refresh_o,
   output logic odt_o,
   output logic rd_drive_o
);
   int low_cnt = 0;
   int gap_cnt = 100;

   // Clock keeps running through power-down, phase unrelated to the core clock
   initial begin
      ck_o = 1'b0;
      #13;
      forever #32 ck_o = ~ck_o;
   end

   // Pin levels at time zero
   initial begin
      reset_n_o = 1'b1;
      cke_o = 1'b1;
      nop_o = 1'b1;
      refresh_o = 1'b0;
      odt_o = 1'b0;
      rd_drive_o = 1'b0;
   end

   // Cycles with CKE low, and cycles since the last CKE rise or refresh
   always @(posedge ck_o) begin
      low_cnt <= cke_o ? 0 : low_cnt + 1;
      gap_cnt <= (!cke_o || refresh_o) ? 0 : gap_cnt + 1;
   end

   // Entry with NOP on the sampling edge, only once relock and refresh time ran out
   task automatic enter_pd();
      while (gap_cnt < T_GAP) @(posedge ck_o);
      @(posedge ck_o);
      cke_o <= 1'b0;
      nop_o <= 1'b1;
      @(posedge ck_o);
   endtask

   // Exit after the minimum low time; stays far below nine refresh intervals
   task automatic exit_pd();
      while (low_cnt < T_PD) @(posedge ck_o);
      @(posedge ck_o);
      cke_o <= 1'b1;
      nop_o <= 1'b1;
      @(posedge ck_o);
   endtask

   // Refresh only after the exit latency
   task automatic do_refresh();
      while (gap_cnt < T_XP) @(posedge ck_o);
      @(posedge ck_o);
      refresh_o <= 1'b1;
      nop_o <= 1'b0;
      @(posedge ck_o);
      refresh_o <= 1'b0;
      nop_o <= 1'b1;
   endtask

   // Reset pin pulse: CKE low on the same edge; release holds RESET# low two more link cycles (128 ns)
   task automatic reset_assert();
      @(posedge ck_o);
      cke_o <= 1'b0;
      reset_n_o <= 1'b0;
   endtask

   task automatic reset_release();
      repeat (2) @(posedge ck_o);
      reset_n_o <= 1'b1;
      repeat (3) @(posedge ck_o);
      cke_o <= 1'b1;
   endtask

   // ODT and read drive levels, changed in idle, in power-down and in reset
   task automatic set_pins(input logic odt, input logic rd);
      @(posedge ck_o);
      odt_o <= odt;
      rd_drive_o <= rd;
   endtask
endmodule

// File: testbench/dram_power_down_reset_test.sv
`timescale 1ns/1ps
module dram_power_down_reset_test;
   localparam int XP = dram_pd_pkg::XP_CYC;
   localparam int XPDLL = dram_pd_pkg::XPDLL_CYC;
   typedef struct packed {
      logic bank;
      logic fast;
      logic [2:0] wr;
      logic act;
      logic pre;
      logic dll;
   } row_s;
   // Power-down kind per bank state and exit mode
   row_s rows [4] = '{
      '{1'b1, 1'b0, 3'h1, 1'b1, 1'b0, 1'b1},
      '{1'b1, 1'b1, 3'h6, 1'b1, 1'b0, 1'b1},
      '{1'b0, 1'b1, 3'h2, 1'b0, 1'b1, 1'b1},
      '{1'b0, 1'b0, 3'h7, 1'b0, 1'b1, 1'b0}};
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic bank_open_i = 1'b0;
   logic op_busy_i = 1'b0;
   logic dll_disable_i = 1'b0;
   logic [15:0] mr0_i = 16'h0000;
   logic init_done_i = 1'b0;
   wire ck, reset_n, cke, nop, refresh, odt, rd_drive;
   wire out_en_n, in_buf_en, dll_on, odt_async, cmd_ok, dll_cmd_ok;
   wire pd_active, pd_precharge, dll_locked, array_unknown;
   wire [1:0] rtt_en;
   wire [2:0] wr_rec;
   wire [15:0] refresh_cnt;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   logic slow;

   ddr_ctrl_model u_ddr_ctrl_model (.ck_o(ck), .reset_n_o(reset_n), .cke_o(cke), .nop_o(nop),
      .refresh_o(refresh), .odt_o(odt), .rd_drive_o(rd_drive));

   dram_power_down_reset #(.DQ_W(16), .XP(XP), .XPDLL(XPDLL)) u_dram_power_down_reset (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ck_i(ck), .reset_n_i(reset_n), .cke_i(cke),
      .nop_i(nop), .refresh_i(refresh), .odt_i(odt), .rd_drive_i(rd_drive), .bank_open_i(bank_open_i),
      .op_busy_i(op_busy_i), .dll_disable_i(dll_disable_i), .mr0_i(mr0_i), .init_done_i(init_done_i),
      .out_en_n_o(out_en_n), .rtt_en_o(rtt_en), .in_buf_en_o(in_buf_en), .dll_on_o(dll_on),
      .odt_async_o(odt_async), .cmd_ok_o(cmd_ok), .dll_cmd_ok_o(dll_cmd_ok), .wr_rec_o(wr_rec),
      .pd_active_o(pd_active), .pd_precharge_o(pd_precharge), .dll_locked_o(dll_locked),
      .array_unknown_o(array_unknown), .refresh_cnt_o(refresh_cnt));

   // Core clock, 4 ns period
   always #2 sys_clk_i = ~sys_clk_i;

   // Cut a hang short
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic ck_wait(input int cnt);
      repeat (cnt) @(posedge ck);
      #1;
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence: table of entries and exits, then termination, refresh and reset cases
   initial begin
      repeat (6) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      ck_wait(12);
      foreach (rows[i]) begin
         @(posedge sys_clk_i);
         bank_open_i <= rows[i].bank;
         mr0_i <= {3'h0, rows[i].fast, rows[i].wr, 9'h000};
         slow = rows[i].pre && !rows[i].dll;
         ck_wait(8);
         u_ddr_ctrl_model.enter_pd();
         ck_wait(5);
         check(pd_active, rows[i].act);
         check(pd_precharge, rows[i].pre);
         check(dll_on, rows[i].dll);
         check(odt_async, slow);
         check(in_buf_en, 1'b0);
         check(wr_rec, rows[i].wr);
         check(dll_locked, rows[i].dll);
         u_ddr_ctrl_model.exit_pd();
         ck_wait(1);
         check(cmd_ok, 1'b0);
         ck_wait(XP + 1);
         check(cmd_ok, 1'b1);
         check(pd_active | pd_precharge, 1'b0);
         check(dll_cmd_ok, !slow);
         n = XP + 2;
         while (dll_cmd_ok !== 1'b1 && n < XPDLL + 6) begin
            ck_wait(1);
            n++;
         end
         if (slow)
            check(n >= XPDLL && n <= XPDLL + 5, 1'b1);
         ck_wait(2);
         check(odt_async, 1'b0);
         check(in_buf_en, 1'b1);
         check(dll_locked, 1'b1);
      end
      u_ddr_ctrl_model.set_pins(1'b1, 1'b0);
      ck_wait(4);
      check(rtt_en, 2'h3);
      u_ddr_ctrl_model.set_pins(1'b1, 1'b1);
      ck_wait(4);
      check(rtt_en, 2'h0);
      check(out_en_n, 1'b0);
      u_ddr_ctrl_model.set_pins(1'b1, 1'b0);
      @(posedge sys_clk_i);
      dll_disable_i <= 1'b1;
      ck_wait(6);
      check(rtt_en, 2'h0);
      check(dll_on, 1'b0);
      @(posedge sys_clk_i);
      dll_disable_i <= 1'b0;
      u_ddr_ctrl_model.set_pins(1'b0, 1'b0);
      ck_wait(6);
      u_ddr_ctrl_model.do_refresh();
      u_ddr_ctrl_model.do_refresh();
      ck_wait(2);
      check(refresh_cnt, 16'h0002);
      // Bank closes while a command is still busy: precharge kind only once it finishes
      @(posedge sys_clk_i);
      bank_open_i <= 1'b1;
      op_busy_i <= 1'b1;
      ck_wait(12);
      u_ddr_ctrl_model.enter_pd();
      ck_wait(4);
      check(pd_active | pd_precharge, 1'b0);
      @(posedge sys_clk_i);
      bank_open_i <= 1'b0;
      ck_wait(4);
      @(posedge sys_clk_i);
      op_busy_i <= 1'b0;
      ck_wait(6);
      check(pd_precharge, 1'b1);
      check(pd_active, 1'b0);
      // Termination on in power-down, so that reset visibly turns it off
      u_ddr_ctrl_model.set_pins(1'b1, 1'b0);
      ck_wait(3);
      check(rtt_en, 2'h3);
      // Reset pin falls in power-down
      u_ddr_ctrl_model.reset_assert();
      ck_wait(2);
      check(pd_precharge, 1'b0);
      check(out_en_n, 1'b1);
      check(rtt_en, 2'h0);
      check(refresh_cnt, 16'h0000);
      check(array_unknown, 1'b1);
      check(dll_locked, 1'b0);
      u_ddr_ctrl_model.set_pins(1'b0, 1'b0);
      u_ddr_ctrl_model.reset_release();
      ck_wait(8);
      @(posedge sys_clk_i);
      init_done_i <= 1'b1;
      ck_wait(2);
      check(array_unknown, 1'b0);
      wrap_up();
   end
endmodule
